// *** rtl/aso_pkg.sv ***
// constants, register map and carrier types of the converter serial output block
//
// Overview of operation
// - Output words valid only after 816 to 832 master periods following sync.
// - frame_strobe_out is high for exactly one master clock period per word.
// - Rising edges of frame strobe and shift clock follow master clock rises.
// - serial_data_out moves to next bit after each shift clock rising edge.
// - Inverted copies of shift clock, data and frame strobe are driven.
// - overrange_flag is asserted while the input lies outside measurable range.
// - sleep_request_n low powers everything down; undriven pin means running.
// - internal_vref_select_n low picks internal reference; undriven means internal.
// - Input is sampled a fixed aperture delay after each master clock rise.
// - Words are two's complement; full scale clips to 7FFFh and 8000h.
// - One 16-bit word leaves for every 16 master clock periods.
// - overrange_flag is active high.
package aso_pkg;

  // word format
  localparam int WORD_W = 16;
  localparam logic [15:0] FS_POS = 16'h7FFF;
  localparam logic [15:0] FS_NEG = 16'h8000;

  // timing, in master clock periods; the aperture delay in mclk cycles
  localparam int SYNC_MIN_PERIODS = 2;
  localparam int SYNC_MAX_PERIODS = 16;
  localparam int SETTLE_MIN_PERIODS = 816;
  localparam int SETTLE_MAX_PERIODS = 832;
  localparam int WORD_PERIODS = 16;
  localparam int APERTURE_CYCLES = 2;

  // register map, word indices on the plain register port
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_MASK = 4'h2;
  localparam logic [3:0] REG_LAST_WORD = 4'h3;
  localparam logic [3:0] REG_STATE = 4'h4;

  // field positions, event count and reset values
  localparam int CTRL_OUT_EN = 0;
  localparam logic [15:0] CTRL_RESET = 16'h0001;
  localparam int EV_SYNC_DONE = 0;
  localparam int EV_SETTLED = 1;
  localparam int EV_OVERRANGE = 2;
  localparam int EV_SYNC_ERR = 3;
  localparam int EV_N = 4;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam int ST_SETTLED = 0;
  localparam int ST_SLEEP = 1;
  localparam int ST_VREF_INT = 2;
  localparam int ST_SYNC_HIGH = 3;

  // synchroniser reset levels: clk, sync, sleep_n (pulled up), vref_n (pulled down)
  localparam logic [3:0] PIN_RESET = 4'b0100;

  // serial pin group
  typedef struct packed {
    logic shift_clock;
    logic serial_data;
    logic frame_strobe;
  } aso_ser_s;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } aso_reg_req_s;

  // serial state
  typedef enum logic [1:0] {
    ST_IDLE_E = 2'b00,
    ST_ALIGN_E = 2'b01,
    ST_SETTLE_E = 2'b10,
    ST_RUN_E = 2'b11
  } aso_state_e;

endpackage : aso_pkg

// *** rtl/aso_sync2.sv ***
// two flip-flop synchroniser for pins from outside the mclk domain
`timescale 1ns/100ps
module aso_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta <= RESET_VAL;
      q <= RESET_VAL;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : aso_sync2

// *** rtl/aso_serial_out.sv ***
// converter digital control: sync, settling, word framing and serial output
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module aso_serial_out #(
  parameter int ACC_W = 18,
  parameter int SETTLE_PERIODS = aso_pkg::SETTLE_MIN_PERIODS,
  parameter int APERTURE = aso_pkg::APERTURE_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic master_clk_in,
  input wire logic sample_align_input,
  input wire logic sleep_request_n,
  input wire logic internal_vref_select_n,
  input wire logic [ACC_W-1:0] filter_sum,
  input wire aso_pkg::aso_reg_req_s reg_req,
  output logic [15:0] reg_rdata,
  output aso_pkg::aso_ser_s ser_out,
  output aso_pkg::aso_ser_s ser_out_inv,
  output logic overrange_flag,
  output logic power_down,
  output logic vref_internal_en,
  output logic sample_strobe,
  output logic irq
);
  import aso_pkg::*;

  localparam int TOP_W = ACC_W - WORD_W + 1;

  logic [3:0] pins_q;
  logic clk_prev;
  logic sync_prev;
  aso_state_e state;
  aso_state_e next_state;
  logic [3:0] phase;
  logic [9:0] settle_cnt;
  logic [4:0] sync_width;
  logic [15:0] shreg;
  logic [15:0] last_word;
  logic [15:0] ctrl;
  logic [EV_N-1:0] status;
  logic [EV_N-1:0] mask;
  logic [APERTURE-1:0] aperture_dly;

  // every pin crosses two flops before use
  aso_sync2 #(.WIDTH(4), .RESET_VAL(PIN_RESET)) u_pin_sync (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .d({internal_vref_select_n, sleep_request_n, sample_align_input, master_clk_in}),
    .q(pins_q)
  );

  // decoded pin levels and master clock edges
  wire clk_s = pins_q[0];
  wire sync_s = pins_q[1];
  wire sleep_s = ~pins_q[2];
  wire vref_int_s = ~pins_q[3];
  wire rise_tick = clk_s & ~clk_prev;
  wire fall_tick = ~clk_s & clk_prev;
  wire sync_fall = rise_tick & ~sync_s & sync_prev;

  // saturation of the filter sum to 16-bit two's complement
  wire [TOP_W-1:0] sum_top = filter_sum[ACC_W-1:WORD_W-1];
  wire sum_over = ~(&sum_top | ~(|sum_top));
  wire [15:0] clip_word = !sum_over ? filter_sum[15:0] :
                          (filter_sum[ACC_W-1] ? FS_NEG : FS_POS);

  // word boundary and event pulses
  wire word_start = rise_tick && (state == ST_SETTLE_E || state == ST_RUN_E) && phase == 4'h0;
  wire settle_hit = rise_tick && state == ST_SETTLE_E && 32'(settle_cnt) == SETTLE_PERIODS - 1;
  wire width_bad = (32'(sync_width) < SYNC_MIN_PERIODS) || (32'(sync_width) > SYNC_MAX_PERIODS);
  wire [EV_N-1:0] ev_set = {sync_fall & width_bad, word_start & sum_over, settle_hit, sync_fall};
  wire rd_status = reg_req.rd && reg_req.addr == REG_STATUS;
  wire out_en = ctrl[CTRL_OUT_EN];

  // state: align while sync high, settle afterward, run once settled
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE_E: begin
        if (rise_tick && sync_s) begin
          next_state = ST_ALIGN_E;
        end else if (rise_tick) begin
          next_state = ST_SETTLE_E;
        end
      end
      ST_ALIGN_E: begin
        if (sync_fall) begin
          next_state = ST_SETTLE_E;
        end
      end
      ST_SETTLE_E: begin
        if (rise_tick && sync_s) begin
          next_state = ST_ALIGN_E;
        end else if (settle_hit) begin
          next_state = ST_RUN_E;
        end
      end
      ST_RUN_E: begin
        if (rise_tick && sync_s) begin
          next_state = ST_ALIGN_E;
        end
      end
      default: begin
        next_state = ST_IDLE_E;
      end
    endcase
    if (sleep_s) begin
      next_state = ST_IDLE_E;
    end
  end

  // edge history and state register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      clk_prev <= 1'b0;
      sync_prev <= 1'b0;
      state <= ST_IDLE_E;
    end else if (ce) begin
      clk_prev <= clk_s;
      if (rise_tick) begin
        sync_prev <= sync_s;
      end
      state <= next_state;
    end
  end

  // sync width in master periods, saturating so long pulses still flag
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync_width <= 5'h00;
    end else if (ce && rise_tick) begin
      if (!sync_s) begin
        sync_width <= 5'h00;
      end else if (sync_width != 5'h1F) begin
        sync_width <= sync_width + 5'h01;
      end
    end
  end

  // settle count and word phase restart from the sync release
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      settle_cnt <= 10'h000;
      phase <= 4'h0;
    end else if (ce && rise_tick) begin
      if (sync_s || sleep_s) begin
        settle_cnt <= 10'h000;
        phase <= 4'h0;
      end else begin
        if (state == ST_SETTLE_E) begin
          settle_cnt <= settle_cnt + 10'h001;
        end
        phase <= phase + 4'h1;
      end
    end
  end

  // serial pins: strobe and clock rise on master rise, data moves with them
  // frames keep leaving during settling; the receiver discards those
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ser_out <= '0;
      ser_out_inv <= '1;
      shreg <= 16'h0000;
      last_word <= 16'h0000;
      overrange_flag <= 1'b0;
    end else if (ce) begin
      if (sleep_s || !out_en || state == ST_IDLE_E || state == ST_ALIGN_E) begin
        ser_out <= '0;
        ser_out_inv <= '1;
      end else if (rise_tick) begin
        ser_out.shift_clock <= 1'b1;
        ser_out_inv.shift_clock <= 1'b0;
        ser_out.frame_strobe <= word_start;
        ser_out_inv.frame_strobe <= ~word_start;
        if (word_start) begin
          ser_out.serial_data <= clip_word[15];
          ser_out_inv.serial_data <= ~clip_word[15];
          shreg <= {clip_word[14:0], 1'b0};
        end else begin
          ser_out.serial_data <= shreg[15];
          ser_out_inv.serial_data <= ~shreg[15];
          shreg <= {shreg[14:0], 1'b0};
        end
      end else if (fall_tick) begin
        ser_out.shift_clock <= 1'b0;
        ser_out_inv.shift_clock <= 1'b1;
      end
      if (word_start) begin
        last_word <= clip_word;
        overrange_flag <= sum_over;
      end
      if (sleep_s) begin
        overrange_flag <= 1'b0;
      end
    end
  end

  // aperture delay: sample strobe a fixed count after each master rise
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      aperture_dly <= '0;
    end else if (ce) begin
      aperture_dly <= {aperture_dly[APERTURE-2:0], rise_tick & ~sleep_s};
    end
  end
  assign sample_strobe = aperture_dly[APERTURE-1];

  // control, mask and sticky status; a new event beats the read clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= CTRL_RESET;
      mask <= MASK_RESET;
      status <= '0;
      power_down <= 1'b0;
      vref_internal_en <= 1'b1;
    end else if (ce) begin
      if (reg_req.wr && reg_req.addr == REG_CTRL) begin
        ctrl <= reg_req.wdata;
      end
      if (reg_req.wr && reg_req.addr == REG_MASK) begin
        mask <= reg_req.wdata[EV_N-1:0];
      end
      status <= (rd_status ? '0 : status) | ev_set;
      power_down <= sleep_s;
      vref_internal_en <= vref_int_s;
    end
  end

  // read mux, answered in the following cycle; unmapped reads zero
  wire [15:0] state_word = {12'h000, sync_s, vref_int_s, sleep_s, state == ST_RUN_E};
  wire [15:0] rd_mux = (reg_req.addr == REG_CTRL) ? ctrl :
                       (reg_req.addr == REG_STATUS) ? {12'h000, status} :
                       (reg_req.addr == REG_MASK) ? {12'h000, mask} :
                       (reg_req.addr == REG_LAST_WORD) ? last_word :
                       (reg_req.addr == REG_STATE) ? state_word : 16'h0000;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (ce) begin
      reg_rdata <= reg_req.rd ? rd_mux : 16'h0000;
    end
  end

  assign irq = |(status & mask);

endmodule : aso_serial_out

// *** verif/aso_rx_model.sv ***
// receiving-end model: rebuilds words from the serial pins
`timescale 1ns/100ps
module aso_rx_model (
  input wire logic mclk,
  input wire logic resetn,
  input wire aso_pkg::aso_ser_s ser,
  output logic [15:0] word,
  output logic word_valid
);
  logic last_clk;
  logic last_dat;
  logic [4:0] cnt;
  logic [15:0] sr;
  wire clk_rise = ser.shift_clock && !last_clk;
  // bit taken just before the line moves on; word done at next frame start
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      last_clk <= 1'b0;
      last_dat <= 1'b0;
      cnt <= 5'h00;
      sr <= 16'h0000;
      word <= 16'h0000;
      word_valid <= 1'b0;
    end else begin
      last_clk <= ser.shift_clock;
      last_dat <= ser.serial_data;
      word_valid <= clk_rise && ser.frame_strobe && cnt == 5'h0F;
      if (clk_rise) begin
        sr <= {sr[14:0], last_dat};
        word <= {sr[14:0], last_dat};
        cnt <= ser.frame_strobe ? 5'h00 : cnt + 5'h01;
      end
    end
  end
endmodule : aso_rx_model

// *** verif/aso_serial_out_props.sv ***
// concurrent checks on the serial output block's pins
`timescale 1ns/100ps
module aso_serial_out_props (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic sample_align_input,
  input wire logic sleep_request_n,
  input wire logic internal_vref_select_n,
  input wire aso_pkg::aso_ser_s ser_out,
  input wire aso_pkg::aso_ser_s ser_out_inv,
  input wire logic power_down,
  input wire logic vref_internal_en,
  input wire logic sample_strobe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // sync or sleep may cut a frame short, so those spans are excused
  property p_fs_width;
    disable iff (!resetn || sample_align_input || !sleep_request_n)
    $rose(ser_out.frame_strobe) |-> ser_out.frame_strobe[*8] ##[1:12] !ser_out.frame_strobe;
  endproperty
  property p_inv; ser_out_inv == ~ser_out; endproperty
  property p_fs_clk; $rose(ser_out.frame_strobe) |-> $rose(ser_out.shift_clock); endproperty
  property p_data; $changed(ser_out.serial_data) && ser_out != '0 |-> $rose(ser_out.shift_clock);
  endproperty
  property p_sleep; $fell(sleep_request_n) |-> ##[1:4] power_down; endproperty
  property p_quiet; power_down[*2] |-> ser_out == '0; endproperty
  property p_vref; $changed(internal_vref_select_n) |-> ##[1:4]
    (vref_internal_en != internal_vref_select_n);
  endproperty
  property p_strobe; sample_strobe |=> !sample_strobe; endproperty
  a_fs_width: assert property (p_fs_width) else $error("frame strobe width wrong");
  a_inv: assert property (p_inv) else $error("complement pins disagree");
  a_fs_clk: assert property (p_fs_clk) else $error("frame without clock edge");
  a_data: assert property (p_data) else $error("data moved off clock edge");
  a_sleep: assert property (p_sleep) else $error("no power down");
  a_quiet: assert property (p_quiet) else $error("pins active in sleep");
  a_vref: assert property (p_vref) else $error("reference select not followed");
  a_strobe: assert property (p_strobe) else $error("sample strobe too long");
  c_frame: cover property ($rose(ser_out.frame_strobe));
  c_sleep: cover property ($rose(power_down));
  c_vref: cover property ($rose(vref_internal_en));
endmodule : aso_serial_out_props
bind aso_serial_out aso_serial_out_props u_props (.mclk(mclk), .resetn(resetn),
  .sample_align_input(sample_align_input), .sleep_request_n(sleep_request_n),
  .internal_vref_select_n(internal_vref_select_n), .ser_out(ser_out),
  .ser_out_inv(ser_out_inv), .power_down(power_down), .vref_internal_en(vref_internal_en),
  .sample_strobe(sample_strobe));

// *** verif/adc_serial_output_sync_tb.sv ***
// self-checking bench for the converter serial output block
`timescale 1ns/100ps
module adc_serial_output_sync_tb;
  import aso_pkg::*;
  localparam int SP = 20;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic mck = 1'b0;
  logic sync = 1'b0;
  logic sleep_n = 1'b1;
  logic vref_n = 1'b1;
  logic chk = 1'b0;
  logic ce_i = 1'b1;
  logic ovr_e = 1'b0;
  logic rd_d = 1'b0;
  logic [17:0] fsum = 18'h00000;
  logic [15:0] w_e = 16'h0000;
  logic [15:0] rdata, rxw, r16;
  logic rxv, ovr, pd, vint, irq;
  aso_reg_req_s req = '0;
  aso_ser_s so, soi;
  logic [15:0] exp_q[$];
  int failures = 0;
  int comparisons = 0;
  int seed = 32'h55b0;
  always #5 mclk = ~mclk;
  // master clock free-running, phase unrelated to mclk
  initial begin
    #33;
    forever #80 mck <= ~mck;
  end
  aso_serial_out #(.SETTLE_PERIODS(SP)) dut (.mclk(mclk), .resetn(resetn), .ce(ce_i),
    .master_clk_in(mck), .sample_align_input(sync), .sleep_request_n(sleep_n),
    .internal_vref_select_n(vref_n), .filter_sum(fsum), .reg_req(req), .reg_rdata(rdata),
    .ser_out(so), .ser_out_inv(soi), .overrange_flag(ovr), .power_down(pd),
    .vref_internal_en(vint), .sample_strobe(), .irq(irq));
  aso_rx_model rx (.mclk(mclk), .resetn(resetn), .ser(so), .word(rxw), .word_valid(rxv));
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask : check
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge mclk);
    req.rd <= 1'b0;
    exp_q.push_back(e);
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask : wr
  // sync held n master periods, then the settle span is waited out
  task automatic pulse(input int n);
    @(posedge mclk);
    sync <= 1'b1;
    repeat (n * 16) @(posedge mclk);
    sync <= 1'b0;
    repeat (SP * 16 + 200) @(posedge mclk);
  endtask : pulse
  // words in flight when the input changes are not judged
  task automatic send_word(input logic [17:0] v, input logic [15:0] w, input logic o);
    @(posedge mclk);
    fsum <= v;
    w_e <= w;
    ovr_e <= o;
    repeat (600) @(posedge mclk);
    chk <= 1'b1;
    repeat (560) @(posedge mclk);
    chk <= 1'b0;
    rd(REG_LAST_WORD, w);
    $display("word %h done", w);
  endtask : send_word
  task automatic end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  // watcher: read data one cycle after the strobe, words as they complete
  always @(posedge mclk) begin
    rd_d <= req.rd;
    if (rd_d) check(rdata, exp_q.pop_front());
    if (rxv && chk) begin
      check(rxw, w_e);
      check({15'h0000, ovr}, {15'h0000, ovr_e});
    end
  end
  initial begin
    repeat (2) @(posedge mclk);
    check({13'h0000, soi}, 16'h0007);
    resetn <= 1'b1;
    rd(REG_CTRL, CTRL_RESET);
    rd(REG_MASK, {12'h000, MASK_RESET});
    rd(4'hF, 16'h0000);
    wr(REG_MASK, 16'h0004);
    pulse(2);
    rd(REG_STATUS, 16'h0003);
    rd(REG_STATUS, 16'h0000);
    rd(REG_STATE, 16'h0001);
    $display("sync test done");
    repeat (2) begin
      r16 = 16'($random(seed));
      send_word({{2{r16[15]}}, r16}, r16, 1'b0);
    end
    send_word(18'h07FFF, FS_POS, 1'b0);
    send_word(18'h38000, FS_NEG, 1'b0);
    send_word(18'h37FFF, FS_NEG, 1'b1);
    send_word(18'h08000, FS_POS, 1'b1);
    check({15'h0000, irq}, 16'h0001);
    send_word(18'h00123, 16'h0123, 1'b0);
    rd(REG_STATUS, 16'h0004);
    repeat (3) @(posedge mclk);
    check({15'h0000, irq}, 16'h0000);
    vref_n <= 1'b0;
    repeat (6) @(posedge mclk);
    check({15'h0000, vint}, 16'h0001);
    sleep_n <= 1'b0;
    repeat (300) @(posedge mclk);
    check({15'h0000, pd}, 16'h0001);
    check({13'h0000, so}, 16'h0000);
    // clock enable low: read is not taken, read data stays frozen at zero
    ce_i <= 1'b0;
    rd(REG_CTRL, 16'h0000);
    @(posedge mclk);
    ce_i <= 1'b1;
    sleep_n <= 1'b1;
    $display("pin test done");
    pulse(17);
    rd(REG_STATUS, 16'h000B);
    repeat (4) @(posedge mclk);
    end_sim;
  end
  initial begin
    #400000;
    failures++;
    end_sim;
  end
endmodule : adc_serial_output_sync_tb
